// >>> rcs_pkg.sv
package rcs_pkg;

    // ----
    // Register map (byte addresses, one word each)
    // ----
    localparam logic [7:0] REG_CAUSE = 8'h00;
    localparam logic [7:0] REG_OSC = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;

    // ----
    // Cause flag positions and values
    // ----
    localparam int BIT_POR = 0;
    localparam int BIT_BOR = 1;
    localparam int BIT_IDLE = 2;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int BIT_SWDT = 5;
    localparam int BIT_SOFT = 6;
    localparam int BIT_PIN = 7;
    localparam int BIT_VREG = 8;
    localparam int BIT_ILLOP = 14;
    localparam int BIT_TRAP = 15;
    localparam logic [15:0] CAUSE_RST_VAL = 16'h0003;
    localparam logic [15:0] CAUSE_WR_MASK = 16'hc1ff;
    localparam logic [15:0] CAUSE_BOR_CLR = 16'hc05c;

    // ----
    // Oscillator field and source codes
    // ----
    localparam int OSC_FIELD_LSB = 12;
    localparam logic [2:0] OSC_FRC = 3'h0;
    localparam logic [2:0] OSC_FRCPLL = 3'h1;
    localparam logic [2:0] OSC_XTAL = 3'h2;
    localparam logic [2:0] OSC_XTALPLL = 3'h3;
    localparam logic [2:0] OSC_SEC = 3'h4;
    localparam logic [2:0] OSC_LPRC = 3'h5;
    localparam logic [2:0] OSC_EXT = 3'h6;
    localparam logic [2:0] OSC_EXTPLL = 3'h7;

    // ----
    // Timing, ns and derived cycle counts at 200 MHz
    // ----
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned T_POR_NS = 10_000;
    localparam int unsigned T_STARTUP_REG_NS = 20_000;
    localparam int unsigned T_STARTUP_LONG_NS = 64_000_000;
    localparam int unsigned T_RST_NS = 20_000;
    localparam int unsigned T_LOCK_NS = 20_000;
    localparam int unsigned T_MONITOR_NS = 500_000;
    localparam int unsigned POR_CYC = (T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_REG_CYC = (T_STARTUP_REG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_LONG_CYC = (T_STARTUP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOCK_CYC = (T_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MONITOR_CYC = (T_MONITOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] SETTLE_LAST = 10'h3ff;

    // ----
    // Types
    // ----
    typedef enum logic [3:0] {
        ST_HOLD = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_CLKWAIT = 4'b0100,
        ST_RUN = 4'b1000
    } rcs_seq_t;

    typedef enum logic [2:0] {
        KIND_POR = 3'b001,
        KIND_BOR = 3'b010,
        KIND_WARM = 3'b100
    } rcs_kind_t;

    typedef struct packed {
        logic por_det;
        logic bor_det;
        logic ext_clear_pin;
        logic osc_tick;
        logic osc_valid;
    } rcs_pin_t;

    typedef struct packed {
        logic wdog_expire;
        logic soft_reset;
        logic trap_conflict;
        logic illegal_op;
        logic sleep_instr;
        logic idle_instr;
    } rcs_core_evt_t;

    typedef struct packed {
        logic regulator_en;
        logic clk_switch_en;
        logic monitor_en;
        logic wdog_fuse_enable;
        logic [2:0] boot_osc_select;
    } rcs_fuse_t;

endpackage

// >>> rcs_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_delay_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic [31:0] load_val,
    output logic expired
);
    logic [31:0] cnt_r;
    logic expired_r;

    // Held load restarts the count every cycle; counting starts on release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 32'h0000_0000;
            expired_r <= 1'b0;
        end else if (load) begin
            cnt_r <= load_val;
            expired_r <= 1'b0;
        end else begin
            if (cnt_r != 32'h0000_0000) begin
                cnt_r <= cnt_r - 32'h0000_0001;
            end
            expired_r <= (cnt_r <= 32'h0000_0001);
        end
    end

    assign expired = expired_r;
endmodule
`default_nettype wire

// >>> rcs_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] Power-on alone sets cause bit 0
// [RQ2] Brown-out or power-on sets bit 1, cleared only by a software write
// [RQ3] Software writes flags freely, never causes reset
// [RQ4] Unprogrammed fuse forces watchdog on
// [RQ5] Trap bit 15, illegal-op bit 14, cold clear
// [RQ6] Watchdog bit 4; power-save or cold clears
// [RQ7] Switching on: cold uses fuses, warm keeps field
// [RQ8] Switching off: always fuse clock source
// [RQ9] Reset line held until the reset delay expires
// [RQ10] Settle and lock run alongside reset delay
// [RQ11] CPU waits for released valid clock
// [RQ12] Power-on delay: power-on plus startup plus internal
// [RQ13] Startup delay depends on regulator enable
// [RQ14] Brown-out: startup plus internal; others internal only
// [RQ15] Crystal sources wait 1024 oscillator periods
// [RQ16] PLL sources wait lock time too
// [RQ17] Monitor start delay after release, crystal/PLL
// [RQ18] Missing clock at monitor start: fast RC, trap
// [RQ19] Only cause and oscillator registers vary by type
// [RQ20] Power-on clears all flags but power-on and brown-out
// [RQ21] Any active source asserts reset line
// [RQ22] Pin flag bit 7, soft flag bit 6
// [RQ23] Sleep bit 3, idle bit 2, cold clear
module rcs_reset_sequencer
    import rcs_pkg::*;
#(
    parameter int unsigned STARTUP_LONG_CYCLES = STARTUP_LONG_CYC,
    parameter int unsigned MONITOR_CYCLES = MONITOR_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire rcs_pin_t pins_async,
    input wire rcs_core_evt_t core_evt,
    input wire rcs_fuse_t fuses,
    output logic system_reset_line,
    output logic cpu_run,
    output logic wdog_enable,
    output logic monitor_active,
    output logic osc_fail_trap,
    output logic [2:0] current_osc_field
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic needs_settle(input logic [2:0] src);
        needs_settle = (src == OSC_XTAL) || (src == OSC_XTALPLL) || (src == OSC_SEC);
    endfunction

    function automatic logic needs_lock(input logic [2:0] src);
        needs_lock = (src == OSC_FRCPLL) || (src == OSC_XTALPLL) || (src == OSC_EXTPLL);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    rcs_pin_t pin_meta_r;
    rcs_pin_t pin_sync_r;
    logic tick_prev_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            tick_prev_r <= 1'b0;
        end else begin
            pin_meta_r <= pins_async;
            pin_sync_r <= pin_meta_r;
            tick_prev_r <= pin_sync_r.osc_tick;
        end
    end

    wire osc_tick_rise = pin_sync_r.osc_tick & ~tick_prev_r;

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    // Bus reset release is treated as a power-on so fuses get loaded
    logic init_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_r <= 1'b1;
        end else begin
            init_r <= 1'b0;
        end
    end

    wire por_act = init_r | pin_sync_r.por_det;
    wire bor_act = pin_sync_r.bor_det;
    wire warm_act = pin_sync_r.ext_clear_pin | core_evt.wdog_expire | core_evt.soft_reset
                    | core_evt.trap_conflict | core_evt.illegal_op;
    wire any_src = por_act | bor_act | warm_act;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    rcs_seq_t state_r;
    rcs_seq_t state_nxt;
    rcs_kind_t kind_r;
    rcs_kind_t kind_nxt;
    logic [2:0] osc_field_r;
    logic [2:0] osc_field_nxt;
    logic rst_done;
    logic lock_done;
    logic mon_done;
    logic [9:0] settle_cnt_r;
    logic settle_done_r;
    logic system_reset_r;
    logic cpu_run_r;
    logic wdog_enable_r;
    logic monitor_active_r;
    logic osc_fail_trap_r;
    logic [15:0] cause_r;
    logic [15:0] cause_nxt;

    wire cold = (kind_r == KIND_POR) || (kind_r == KIND_BOR);
    wire hold_exit = (state_r == ST_HOLD) && !any_src;
    wire take_fuse = cold || !fuses.clk_switch_en;
    wire [2:0] sel_osc = take_fuse ? fuses.boot_osc_select : osc_field_r;

    // Strongest source seen during one hold decides the delay
    assign kind_nxt = por_act ? KIND_POR :
                      (bor_act && (state_r != ST_HOLD || kind_r != KIND_POR)) ? KIND_BOR :
                      (state_r != ST_HOLD && warm_act) ? KIND_WARM : kind_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_HOLD: begin
                if (!any_src) begin
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (rst_done) begin
                    state_nxt = ST_CLKWAIT;
                end
            end
            ST_CLKWAIT: begin
                if (lock_done && (settle_done_r || !(cold && needs_settle(osc_field_r)))) begin
                    state_nxt = ST_RUN; // [RQ11]
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
        if (any_src) begin
            state_nxt = ST_HOLD; // [RQ21]
        end
    end

    // ------------------------------------------------------------
    // Delay timers
    // ------------------------------------------------------------
    wire [31:0] startup_cyc = fuses.regulator_en ? 32'(STARTUP_REG_CYC)
                                                 : 32'(STARTUP_LONG_CYCLES); // [RQ13]
    wire [31:0] rst_load_val = (kind_nxt == KIND_POR) ? 32'(POR_CYC) + startup_cyc + 32'(RST_CYC)
                             : (kind_nxt == KIND_BOR) ? startup_cyc + 32'(RST_CYC)
                             : 32'(RST_CYC); // [RQ12] [RQ14]
    wire [31:0] lock_load_val = (cold && needs_lock(sel_osc)) ? 32'(LOCK_CYC)
                                                              : 32'h0000_0000; // [RQ16]
    wire [31:0] mon_load_val = (cold && (needs_settle(sel_osc) || needs_lock(sel_osc)))
                             ? 32'(MONITOR_CYCLES) : 32'h0000_0000; // [RQ17]
    wire in_hold = (state_r == ST_HOLD) || any_src;

    rcs_delay_timer u_rst_tmr (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(in_hold),
        .load_val(rst_load_val),
        .expired(rst_done)
    ); // [RQ9]

    // Lock wait starts with the reset delay, not after it
    rcs_delay_timer u_lock_tmr (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(in_hold),
        .load_val(lock_load_val),
        .expired(lock_done)
    ); // [RQ10]

    // Monitor delay counts from reset line release
    rcs_delay_timer u_mon_tmr (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(system_reset_r),
        .load_val(mon_load_val),
        .expired(mon_done)
    ); // [RQ17]

    // Oscillator periods counted in parallel with the reset delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_cnt_r <= 10'h000;
            settle_done_r <= 1'b0;
        end else if (in_hold) begin
            settle_cnt_r <= 10'h000;
            settle_done_r <= 1'b0;
        end else if (osc_tick_rise && !settle_done_r) begin
            settle_cnt_r <= settle_cnt_r + 10'h001;
            settle_done_r <= (settle_cnt_r == SETTLE_LAST); // [RQ15] [RQ10]
        end
    end

    // ------------------------------------------------------------
    // Clock source and monitor
    // ------------------------------------------------------------
    wire clk_fail = monitor_active_r && !pin_sync_r.osc_valid && (osc_field_r != OSC_FRC);

    always_comb begin
        osc_field_nxt = osc_field_r;
        if (hold_exit) begin
            osc_field_nxt = sel_osc; // [RQ7] [RQ8] [RQ19]
        end else if (clk_fail) begin
            osc_field_nxt = OSC_FRC; // [RQ18]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_HOLD;
            kind_r <= KIND_POR;
            osc_field_r <= OSC_FRC;
            system_reset_r <= 1'b1;
            cpu_run_r <= 1'b0;
            wdog_enable_r <= 1'b1;
            monitor_active_r <= 1'b0;
            osc_fail_trap_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            osc_field_r <= osc_field_nxt;
            system_reset_r <= (state_nxt == ST_HOLD) || (state_nxt == ST_DELAY); // [RQ9]
            cpu_run_r <= (state_nxt == ST_RUN); // [RQ11]
            wdog_enable_r <= fuses.wdog_fuse_enable | cause_nxt[BIT_SWDT]; // [RQ4]
            monitor_active_r <= fuses.monitor_en && mon_done && !system_reset_r && !any_src;
            osc_fail_trap_r <= clk_fail; // [RQ18]
        end
    end

    // ------------------------------------------------------------
    // Cause flags
    // ------------------------------------------------------------
    logic wr_pend_r;
    logic [7:0] wr_addr_r;

    // Hardware sets come after the write and brown-out clears so a same-cycle event wins; power-on load comes last
    always_comb begin
        cause_nxt = cause_r;
        if (wr_pend_r && wr_addr_r == REG_CAUSE) begin
            cause_nxt = hwdata[15:0] & CAUSE_WR_MASK; // [RQ3]
        end
        if (bor_act) begin
            cause_nxt = cause_nxt & ~CAUSE_BOR_CLR; // [RQ5] [RQ6] [RQ22] [RQ23]
        end
        if (core_evt.sleep_instr || core_evt.idle_instr) begin
            cause_nxt[BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0; // [RQ6]
        end
        if (core_evt.trap_conflict) begin
            cause_nxt[BIT_TRAP] = 1'b1; // [RQ5]
        end
        if (core_evt.illegal_op) begin
            cause_nxt[BIT_ILLOP] = 1'b1; // [RQ5]
        end
        if (pin_sync_r.ext_clear_pin) begin
            cause_nxt[BIT_PIN] = 1'b1; // [RQ22]
        end
        if (core_evt.soft_reset) begin
            cause_nxt[BIT_SOFT] = 1'b1; // [RQ22]
        end
        if (core_evt.wdog_expire) begin
            cause_nxt[BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1; // [RQ6]
        end
        if (core_evt.sleep_instr) begin
            cause_nxt[BIT_SLEEP] = 1'b1; // [RQ23]
        end
        if (core_evt.idle_instr) begin
            cause_nxt[BIT_IDLE] = 1'b1; // [RQ23]
        end
        if (bor_act) begin
            cause_nxt[BIT_BOR] = 1'b1; // [RQ2]
        end
        if (por_act) begin
            cause_nxt = CAUSE_RST_VAL; // [RQ1] [RQ2] [RQ20]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_r <= CAUSE_RST_VAL;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Zero wait states; reads return post-write values so a read right
    // after a write to the same word sees the new data
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;

    wire accept = hsel && htrans[1] && hready;
    wire [7:0] acc_addr = haddr[7:0];
    wire addr_hi_ok = (haddr[31:8] == 24'h00_0000);
    wire [31:0] osc_word = {17'h0_0000, osc_field_nxt, 12'h000};
    wire [31:0] stat_word = {25'h000_0000, fuses.regulator_en, wdog_enable_r, osc_fail_trap_r,
                             monitor_active_r, cpu_run_r, state_r == ST_RUN, system_reset_r};
    wire [31:0] rd_val = !addr_hi_ok ? 32'h0000_0000
                       : (acc_addr == REG_CAUSE) ? {16'h0000, cause_nxt}
                       : (acc_addr == REG_OSC) ? osc_word
                       : (acc_addr == REG_STAT) ? stat_word
                       : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            wr_pend_r <= accept && hwrite && addr_hi_ok;
            if (accept) begin
                wr_addr_r <= acc_addr;
            end
            if (accept && !hwrite) begin
                hrdata_r <= rd_val;
            end
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;
    assign system_reset_line = system_reset_r;
    assign cpu_run = cpu_run_r;
    assign wdog_enable = wdog_enable_r;
    assign monitor_active = monitor_active_r;
    assign osc_fail_trap = osc_fail_trap_r;
    assign current_osc_field = osc_field_r;

endmodule
`default_nettype wire

// >>> rcs_reset_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_sequencer_chk
    import rcs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire rcs_pin_t pins_async,
    input wire rcs_core_evt_t core_evt,
    input wire rcs_fuse_t fuses,
    input wire logic system_reset_line,
    input wire logic cpu_run,
    input wire logic wdog_enable,
    input wire logic monitor_active,
    input wire logic osc_fail_trap,
    input wire logic [2:0] current_osc_field
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----
    // Helpers
    // ----
    wire logic wr_take;
    logic [15:0] hi_cnt_r;
    assign wr_take = hsel & htrans[1] & hready & hwrite;
    // Saturates so a long hold never wraps to a small count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hi_cnt_r <= 16'h0;
        else if (!system_reset_line)
            hi_cnt_r <= 16'h0;
        else if (hi_cnt_r != 16'hffff)
            hi_cnt_r <= hi_cnt_r + 16'h1;
    end
    // ----
    // Properties
    // ----
    property p_por_src;
        pins_async.por_det |-> ##[1:4] system_reset_line;
    endproperty
    a_por_src: assert property (p_por_src) else $error("power-on source did not hold reset");
    property p_core_src;
        (core_evt.wdog_expire | core_evt.soft_reset | core_evt.trap_conflict
            | core_evt.illegal_op) |-> ##[1:2] system_reset_line;
    endproperty
    a_core_src: assert property (p_core_src) else $error("core source did not assert reset");
    property p_min_hold;
        $fell(system_reset_line) |-> hi_cnt_r >= 16'(RST_CYC);
    endproperty
    a_min_hold: assert property (p_min_hold) else $error("reset line released too early");
    property p_run_gate;
        cpu_run |-> !system_reset_line;
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("core runs while reset held");
    property p_wr_quiet;
        !system_reset_line && wr_take && core_evt == '0 && $past(core_evt) == '0
            && pins_async[4:2] == 3'h0 && $past(pins_async[4:2]) == 3'h0
            && $past(pins_async[4:2], 2) == 3'h0 |=> !system_reset_line;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("register write caused reset");
    property p_wdog_fuse;
        fuses.wdog_fuse_enable [*2] |-> wdog_enable;
    endproperty
    a_wdog_fuse: assert property (p_wdog_fuse) else $error("watchdog off with fuse set");
    property p_trap_pulse;
        osc_fail_trap |=> !osc_fail_trap;
    endproperty
    a_trap_pulse: assert property (p_trap_pulse) else $error("failure trap longer than one cycle");
    property p_trap_frc;
        osc_fail_trap |-> ##[0:2] current_osc_field == OSC_FRC;
    endproperty
    a_trap_frc: assert property (p_trap_frc) else $error("no switch to fast rc on failure");
    property p_mon_rel;
        monitor_active |-> !system_reset_line;
    endproperty
    a_mon_rel: assert property (p_mon_rel) else $error("monitor active during reset");
    property p_sw_off;
        $fell(system_reset_line) && !fuses.clk_switch_en
            |-> current_osc_field == fuses.boot_osc_select;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("fuse clock not used");
endmodule
bind rcs_reset_sequencer rcs_reset_sequencer_chk chk_u (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hready, .pins_async, .core_evt,
    .fuses, .system_reset_line, .cpu_run, .wdog_enable, .monitor_active,
    .osc_fail_trap, .current_osc_field);
`default_nettype wire

// >>> rcs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_far_model
    import rcs_pkg::*;
(
    input wire logic hclk,
    input wire logic [8:0] fire,
    input wire logic osc_run,
    input wire logic osc_ok,
    output rcs_pin_t pins,
    output rcs_core_evt_t evt
);
    logic [2:0] src_r = 3'h0;
    logic [2:0] hold_r = 3'h0;
    logic [5:0] evt_r = 6'h0;
    logic tick_r = 1'b0;
    // ----
    // Reset sources
    // ----
    // Pin sources held long enough to cross the input synchroniser
    always @(posedge hclk) begin
        evt_r <= fire[5:0];
        if (fire[8:6] != 3'h0) begin
            src_r <= fire[8:6];
            hold_r <= 3'h5;
        end else if (hold_r != 3'h0)
            hold_r <= hold_r - 3'h1;
        else
            src_r <= 3'h0;
    end
    // ----
    // Oscillator
    // ----
    // Stands still when stopped; period unrelated to hclk
    always begin
        #11;
        tick_r = osc_run ? ~tick_r : 1'b0;
    end
    assign pins = {src_r, tick_r, osc_ok};
    assign evt = evt_r;
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rcs_pkg::*;
    localparam int unsigned SLC = 50;
    localparam int unsigned MON = 40;
    localparam int EV[5] = '{5, 4, 3, 2, 6};
    localparam int FB[5] = '{4, 6, 15, 14, 7};
    logic hclk, hresetn, hsel, hwrite, osc_run, osc_ok;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [8:0] fire;
    rcs_fuse_t fuses;
    wire logic hreadyout, hresp, system_reset_line, cpu_run, wdog_enable;
    wire logic monitor_active, osc_fail_trap;
    wire logic [31:0] hrdata;
    wire logic [2:0] current_osc_field;
    wire rcs_pin_t pins;
    wire rcs_core_evt_t evt;
    int num_errors = 0;
    int cmp_count = 0;
    int c;
    rcs_reset_sequencer #(.STARTUP_LONG_CYCLES(SLC), .MONITOR_CYCLES(MON)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins_async(pins),
        .core_evt(evt), .fuses(fuses), .system_reset_line(system_reset_line),
        .cpu_run(cpu_run), .wdog_enable(wdog_enable), .monitor_active(monitor_active),
        .osc_fail_trap(osc_fail_trap), .current_osc_field(current_osc_field));
    rcs_far_model far_u (.hclk(hclk), .fire(fire), .osc_run(osc_run), .osc_ok(osc_ok),
        .pins(pins), .evt(evt));
    // ----
    // Tasks
    // ----
    task automatic stop_test();
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    // Length of the reset pulse, counted from its start
    task automatic wait_rel(input int unsigned n);
        c = 0;
        repeat (10) if (system_reset_line !== 1'b1) @(posedge hclk);
        while (system_reset_line !== 1'b0) begin
            @(posedge hclk);
            c++;
        end
        chk("reset_len", 32'h1, 32'(c >= n && c <= n + 12));
    endtask
    task automatic pulse(input int i);
        @(posedge hclk);
        fire <= 9'h1 << i;
        @(posedge hclk);
        fire <= 9'h0;
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    initial begin
        repeat (100000) @(posedge hclk);
        num_errors++;
        stop_test();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fire = 9'h0;
        osc_run = 1'b1;
        osc_ok = 1'b1;
        fuses = '{1'b0, 1'b1, 1'b1, 1'b1, OSC_XTAL};
        repeat (4) @(posedge hclk);
        chk("reset_line", 32'h1, 32'(system_reset_line));
        hresetn <= 1'b1;
        wait_rel(POR_CYC + SLC + RST_CYC);
        repeat (4) @(posedge hclk);
        chk("cpu_run", 32'h1, 32'(cpu_run));
        chk("mon_early", 32'h0, 32'(monitor_active));
        repeat (MON) @(posedge hclk);
        chk("mon_on", 32'h1, 32'(monitor_active));
        rd_chk("status", REG_STAT, 32'h2e);
        rd_chk("cause_por", REG_CAUSE, 32'h3);
        rd_chk("osc_cold", REG_OSC, 32'(OSC_XTAL) << OSC_FIELD_LSB);
        bus(1'b1, REG_CAUSE, 32'hffff);
        rd_chk("cause_wr", REG_CAUSE, {16'h0, CAUSE_WR_MASK});
        chk("no_reset", 32'h0, 32'(system_reset_line));
        bus(1'b1, REG_CAUSE, 32'h0);
        chk("wdog_fuse", 32'h1, 32'(wdog_enable));
        fuses.wdog_fuse_enable <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("wdog_off", 32'h0, 32'(wdog_enable));
        bus(1'b1, REG_CAUSE, 32'h30);
        repeat (2) @(posedge hclk);
        chk("wdog_soft", 32'h1, 32'(wdog_enable));
        pulse(1);
        pulse(0);
        repeat (2) @(posedge hclk);
        rd_chk("cause_psave", REG_CAUSE, 32'h2c);
        fuses.boot_osc_select <= OSC_SEC;
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, REG_CAUSE, 32'h0);
            pulse(EV[k]);
            wait_rel(RST_CYC);
            rd_chk("cause_warm", REG_CAUSE, 32'h1 << FB[k]);
        end
        rd_chk("osc_warm", REG_OSC, 32'(OSC_XTAL) << OSC_FIELD_LSB);
        bus(1'b1, REG_CAUSE, 32'hffff);
        pulse(7);
        wait_rel(SLC + RST_CYC);
        rd_chk("cause_bor", REG_CAUSE, 32'h01a3);
        rd_chk("osc_bor", REG_OSC, 32'(OSC_SEC) << OSC_FIELD_LSB);
        fuses.clk_switch_en <= 1'b0;
        fuses.boot_osc_select <= OSC_FRC;
        pulse(4);
        wait_rel(RST_CYC);
        rd_chk("osc_fixed", REG_OSC, 32'(OSC_FRC) << OSC_FIELD_LSB);
        fuses.clk_switch_en <= 1'b1;
        fuses.boot_osc_select <= OSC_XTAL;
        osc_ok <= 1'b0;
        bus(1'b1, REG_CAUSE, 32'hffff);
        pulse(8);
        wait_rel(POR_CYC + SLC + RST_CYC);
        c = 0;
        while (osc_fail_trap !== 1'b1 && c < MON + 20) begin
            @(posedge hclk);
            c++;
        end
        chk("fail_trap", 32'h1, 32'(osc_fail_trap));
        repeat (3) @(posedge hclk);
        chk("osc_frc", 32'(OSC_FRC), 32'(current_osc_field));
        rd_chk("cause_por2", REG_CAUSE, 32'h3);
        stop_test();
    end
endmodule
`default_nettype wire
